// [rtl/ccirs_map.vh]
// Register map, field positions and timing constants of the init sequencer.
`ifndef CCIRS_MAP_VH
`define CCIRS_MAP_VH

// ==========================================================================
// Bus register offsets (byte addresses, low byte of haddr)
`define CCIRS_A_CTRL      8'h00
`define CCIRS_A_STATUS    8'h04
`define CCIRS_A_CFG_COUNT 8'h08
`define CCIRS_A_SYSREF    8'h0c
`define CCIRS_A_CHAN_ADDR 8'h10
`define CCIRS_A_CHAN_DATA 8'h14
`define CCIRS_A_TBL_IDX   8'h18
`define CCIRS_A_TBL_DATA  8'h1c
`define CCIRS_A_LAST_RD   8'h20

// ==========================================================================
// Command bits of the control register
`define CCIRS_C_INIT      0
`define CCIRS_C_PULSE     1
`define CCIRS_C_SHUTDOWN  2
`define CCIRS_C_RESYNC    3
`define CCIRS_C_RS_PULSE  4

// ==========================================================================
// Reset values
`define CCIRS_R_SYSREF    16'h0064
`define CCIRS_R_COUNT     7'h00

// ==========================================================================
// Serial frame: read flag, 15-bit device address, 8-bit data
`define CCIRS_FRAME_BITS  24
`define CCIRS_LAST_BIT    5'h17
`define CCIRS_PHASE_ADDR  15'h007d
`define CCIRS_PHASE_BIT   3'h2

// ==========================================================================
// Timing
`define CCIRS_VCO_WAIT_MS     10
`define CCIRS_SETTLE_PERIODS  32'h0000_0006
`define CCIRS_PULSE_PERIODS   32'h0000_0014
`define CCIRS_RST_HOLD_CYC    32'h0000_0010

`endif

// [rtl/ccirs_cfg_mem.v]
// Configuration write list memory with registered read data.
`default_nettype none

module ccirs_cfg_mem #(
  parameter AW = 6,
  parameter DW = 23
) (
  // Clock
  input  wire          clk,
  // Write port
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  // Read port
  input  wire [AW-1:0] raddr,
  output reg  [DW-1:0] rdata
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule // ccirs_cfg_mem

`default_nettype wire

// [rtl/ccirs_ctrl.v]
// Host-side bring-up, SYSREF shutdown and resync sequencer for a clock chip.
`include "ccirs_map.vh"
`default_nettype none

// What this block does
// - Release device reset after supplies are stable.
// - Write vendor configuration updates after reset.
// - Program second loop range and dividers.
// - Program first loop timer, dividers, terminations.
// - Program SYSREF timer ratio and pulse mode.
// - Program every output channel's settings.
// - Wait 10 ms after second loop setup.
// - Require references and oscillator power first.
// - Toggle restart bit one then zero.
// - Poll second loop lock bit after restart.
// - Set reseed bit to align divider phases.
// - Wait six SYSREF periods after sync.
// - Confirm phase status bit equals one.
// - Wait for first loop lock, non-blocking.
// - Issue pulse request when slaves ready.
// - Silence slaves, then clear channel enables.
// - Resync sets channel and sync enables.
// - Reseed, then re-enable slave SYSREF sensitivity.
// - Pulse request twenty periods after reseed.
module ccirs_ctrl #(
  parameter        CLK_HZ        = 100000000,
  parameter        VCO_WAIT_CYC  = `CCIRS_VCO_WAIT_MS * (CLK_HZ / 1000),
  parameter        POLL_GAP_CYC  = 1000,
  parameter [7:0]  SPI_HALF      = 8'h04,
  parameter        TBL_AW        = 6,
  parameter [14:0] RESTART_ADDR  = 15'h0001,
  parameter [7:0]  RESTART_VAL   = 8'h01,
  parameter [14:0] RESEED_ADDR   = 15'h0002,
  parameter [7:0]  RESEED_VAL    = 8'h01,
  parameter [14:0] PULSE_ADDR    = 15'h0002,
  parameter [7:0]  PULSE_VAL     = 8'h02,
  parameter [14:0] PLL2_ST_ADDR  = 15'h0003,
  parameter [2:0]  PLL2_ST_BIT   = 3'h0,
  parameter [14:0] PLL1_ST_ADDR  = 15'h0004,
  parameter [2:0]  PLL1_ST_BIT   = 3'h0,
  parameter [7:0]  CHAN_EN_MASK  = 8'h01
) (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Device pins
  output reg         dev_reset,
  output reg         spi_sclk,
  output reg         spi_cs_n,
  output reg         spi_mosi,
  input  wire        spi_miso,
  // Board status and slave control
  input  wire        supply_ok,
  input  wire        ref_present,
  input  wire        vcxo_powered,
  output reg         slave_sysref_en
);

  // ========================================================================
  // States
  localparam [4:0] S_IDLE     = 5'h00;
  localparam [4:0] S_RST      = 5'h01;
  localparam [4:0] S_TBL_RD   = 5'h02;
  localparam [4:0] S_TBL_GO   = 5'h03;
  localparam [4:0] S_REF      = 5'h04;
  localparam [4:0] S_PLL2_RD  = 5'h05;
  localparam [4:0] S_PLL2_CHK = 5'h06;
  localparam [4:0] S_RESEED   = 5'h07;
  localparam [4:0] S_PH_RD    = 5'h08;
  localparam [4:0] S_PH_CHK   = 5'h09;
  localparam [4:0] S_PLL1_RD  = 5'h0a;
  localparam [4:0] S_PLL1_CHK = 5'h0b;
  localparam [4:0] S_PULSE    = 5'h0c;
  localparam [4:0] S_SHUT_CH  = 5'h0d;
  localparam [4:0] S_RS_CH    = 5'h0e;
  localparam [4:0] S_RS_SLV   = 5'h0f;
  localparam [4:0] S_SPI      = 5'h10;
  localparam [4:0] S_GAP      = 5'h11;
  localparam [4:0] S_WAIT     = 5'h12;
  localparam [4:0] S_SETTLE   = 5'h13;
  localparam [4:0] S_RESTART  = 5'h14;
  localparam [4:0] S_RS_SEED  = 5'h15;

  // ========================================================================
  // Input synchronisers: miso, supply, reference, oscillator power
  wire [3:0] raw_in = {vcxo_powered, ref_present, supply_ok, spi_miso};
  reg  [3:0] in_meta_reg;
  reg  [3:0] in_sync_reg;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          in_meta_reg[gi] <= 1'b0;
          in_sync_reg[gi] <= 1'b0;
        end else begin
          in_meta_reg[gi] <= raw_in[gi];
          in_sync_reg[gi] <= in_meta_reg[gi];
        end
      end
    end
  endgenerate
  wire miso_s = in_sync_reg[0];

  // ========================================================================
  // Software registers
  reg [4:0]        state_reg;
  reg [4:0]        ret_reg;
  reg [TBL_AW:0]   cfg_count_reg;
  reg [TBL_AW-1:0] tbl_wr_idx_reg;
  reg [TBL_AW:0]   tbl_rd_idx_reg;
  reg [15:0]       sysref_cyc_reg;
  reg [14:0]       chan_addr_reg;
  reg [7:0]        chan_data_reg;
  reg [7:0]        last_rd_reg;
  reg [4:0]        cmd_reg;
  reg              rs_pulse_reg;
  reg              pll2_lock_reg;
  reg              pll1_lock_reg;
  reg              phases_ok_reg;
  reg              wr_pend_reg;
  reg [7:0]        wr_addr_reg;

  wire        busy     = (state_reg != S_IDLE);
  wire        ahb_take = hsel & htrans[1] & hready;
  wire [22:0] tbl_q;

  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    if (haddr[7:0] == `CCIRS_A_STATUS) begin
      rd_mux = {22'h0, state_reg, pll1_lock_reg, phases_ok_reg,
                pll2_lock_reg, slave_sysref_en, busy};
    end else if (haddr[7:0] == `CCIRS_A_CFG_COUNT) begin
      rd_mux = {{(31-TBL_AW){1'b0}}, cfg_count_reg};
    end else if (haddr[7:0] == `CCIRS_A_SYSREF) begin
      rd_mux = {16'h0, sysref_cyc_reg};
    end else if (haddr[7:0] == `CCIRS_A_CHAN_ADDR) begin
      rd_mux = {17'h0, chan_addr_reg};
    end else if (haddr[7:0] == `CCIRS_A_CHAN_DATA) begin
      rd_mux = {24'h0, chan_data_reg};
    end else if (haddr[7:0] == `CCIRS_A_TBL_IDX) begin
      rd_mux = {{(32-TBL_AW){1'b0}}, tbl_wr_idx_reg};
    end else if (haddr[7:0] == `CCIRS_A_LAST_RD) begin
      rd_mux = {24'h0, last_rd_reg};
    end
  end

  // Zero-wait slave: reads answer from a register loaded at the address
  // phase, writes land at the data phase edge.
  wire tbl_we = wr_pend_reg && (wr_addr_reg == `CCIRS_A_TBL_DATA);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata         <= 32'h0000_0000;
      hreadyout      <= 1'b1;
      hresp          <= 1'b0;
      wr_pend_reg    <= 1'b0;
      wr_addr_reg    <= 8'h00;
      cmd_reg        <= 5'h00;
      cfg_count_reg  <= `CCIRS_R_COUNT;
      tbl_wr_idx_reg <= {TBL_AW{1'b0}};
      sysref_cyc_reg <= `CCIRS_R_SYSREF;
      chan_addr_reg  <= 15'h0000;
      chan_data_reg  <= 8'h00;
    end else begin
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      cmd_reg     <= 5'h00;
      wr_pend_reg <= ahb_take & hwrite;
      if (ahb_take) begin
        wr_addr_reg <= haddr[7:0];
        if (!hwrite) begin
          hrdata <= rd_mux;
        end
      end
      if (wr_pend_reg) begin
        if (wr_addr_reg == `CCIRS_A_CTRL) begin
          cmd_reg <= hwdata[4:0];
        end else if (wr_addr_reg == `CCIRS_A_CFG_COUNT) begin
          cfg_count_reg <= hwdata[TBL_AW:0];
        end else if (wr_addr_reg == `CCIRS_A_SYSREF) begin
          sysref_cyc_reg <= hwdata[15:0];
        end else if (wr_addr_reg == `CCIRS_A_CHAN_ADDR) begin
          chan_addr_reg <= hwdata[14:0];
        end else if (wr_addr_reg == `CCIRS_A_CHAN_DATA) begin
          chan_data_reg <= hwdata[7:0];
        end else if (wr_addr_reg == `CCIRS_A_TBL_IDX) begin
          tbl_wr_idx_reg <= hwdata[TBL_AW-1:0];
        end else if (tbl_we) begin
          tbl_wr_idx_reg <= tbl_wr_idx_reg + 1'b1;
        end
      end
    end
  end

  ccirs_cfg_mem #(
    .AW (TBL_AW),
    .DW (23)
  ) u_tbl (
    .clk   (hclk),
    .we    (tbl_we),
    .waddr (tbl_wr_idx_reg),
    .wdata (hwdata[22:0]),
    .raddr (tbl_rd_idx_reg[TBL_AW-1:0]),
    .rdata (tbl_q)
  );

  // ========================================================================
  // Serial engine and sequencer
  reg [7:0]  div_reg;
  reg [4:0]  bit_reg;
  reg [23:0] sh_out_reg;
  reg [7:0]  sh_in_reg;
  reg [14:0] op_addr_reg;
  reg        clr_after_reg;
  reg [31:0] wait_reg;

  wire        tick    = (div_reg == SPI_HALF - 8'h01);
  wire [31:0] sr_wide = {16'h0000, sysref_cyc_reg};

  // One device access; with clr set, the same address is written with zero
  // afterwards so that request bits behave as one-then-zero toggles.
  task start_op;
    input        rd;
    input [14:0] addr;
    input [7:0]  data;
    input [4:0]  ret;
    input        clr;
    begin
      sh_out_reg    <= {rd, addr, data};
      spi_mosi      <= rd;
      spi_cs_n      <= 1'b0;
      spi_sclk      <= 1'b0;
      bit_reg       <= 5'h00;
      div_reg       <= 8'h00;
      op_addr_reg   <= addr;
      ret_reg       <= ret;
      clr_after_reg <= clr;
      state_reg     <= S_SPI;
    end
  endtask

  task start_wait;
    input [31:0] cyc;
    input [4:0]  ret;
    begin
      wait_reg  <= cyc;
      ret_reg   <= ret;
      state_reg <= S_WAIT;
    end
  endtask

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg       <= S_IDLE;
      ret_reg         <= S_IDLE;
      dev_reset       <= 1'b1;
      spi_sclk        <= 1'b0;
      spi_cs_n        <= 1'b1;
      spi_mosi        <= 1'b0;
      slave_sysref_en <= 1'b0;
      div_reg         <= 8'h00;
      bit_reg         <= 5'h00;
      sh_out_reg      <= 24'h000000;
      sh_in_reg       <= 8'h00;
      op_addr_reg     <= 15'h0000;
      clr_after_reg   <= 1'b0;
      wait_reg        <= 32'h0000_0000;
      tbl_rd_idx_reg  <= {(TBL_AW+1){1'b0}};
      last_rd_reg     <= 8'h00;
      rs_pulse_reg    <= 1'b0;
      pll2_lock_reg   <= 1'b0;
      pll1_lock_reg   <= 1'b0;
      phases_ok_reg   <= 1'b0;
    end else begin
      div_reg <= tick ? 8'h00 : div_reg + 8'h01;
      case (state_reg)
        S_IDLE: begin
          if (cmd_reg[`CCIRS_C_INIT]) begin
            dev_reset       <= 1'b1;
            slave_sysref_en <= 1'b0;
            pll2_lock_reg   <= 1'b0;
            pll1_lock_reg   <= 1'b0;
            phases_ok_reg   <= 1'b0;
            tbl_rd_idx_reg  <= {(TBL_AW+1){1'b0}};
            start_wait(`CCIRS_RST_HOLD_CYC, S_RST);
          end else if (cmd_reg[`CCIRS_C_SHUTDOWN]) begin
            slave_sysref_en <= 1'b0;
            state_reg       <= S_SHUT_CH;
          end else if (cmd_reg[`CCIRS_C_RESYNC]) begin
            rs_pulse_reg <= cmd_reg[`CCIRS_C_RS_PULSE];
            state_reg    <= S_RS_CH;
          end else if (cmd_reg[`CCIRS_C_PULSE]) begin
            state_reg <= S_PULSE;
          end
        end
        S_RST: begin
          if (in_sync_reg[1]) begin
            dev_reset <= 1'b0;
            start_wait(`CCIRS_RST_HOLD_CYC, S_TBL_RD);
          end
        end
        S_TBL_RD: begin
          // Table holds updates, second loop, first loop, timer, channels.
          if (tbl_rd_idx_reg == cfg_count_reg) begin
            start_wait(VCO_WAIT_CYC, S_REF);
          end else begin
            state_reg <= S_TBL_GO;
          end
        end
        S_TBL_GO: begin
          tbl_rd_idx_reg <= tbl_rd_idx_reg + 1'b1;
          start_op(1'b0, tbl_q[22:8], tbl_q[7:0], S_TBL_RD,
                   1'b0);
        end
        S_REF: begin
          if (in_sync_reg[2] && in_sync_reg[3]) begin
            state_reg <= S_RESTART;
          end
        end
        S_RESTART: begin
          start_op(1'b0, RESTART_ADDR, RESTART_VAL, S_PLL2_RD,
                   1'b1);
        end
        S_PLL2_RD: begin
          start_op(1'b1, PLL2_ST_ADDR, 8'h00, S_PLL2_CHK, 1'b0);
        end
        S_PLL2_CHK: begin
          if (sh_in_reg[PLL2_ST_BIT]) begin
            pll2_lock_reg <= 1'b1;
            state_reg     <= S_RESEED;
          end else begin
            start_wait(POLL_GAP_CYC, S_PLL2_RD);
          end
        end
        S_RESEED: begin
          start_op(1'b0, RESEED_ADDR, RESEED_VAL, S_SETTLE,
                   1'b1);
        end
        S_SETTLE: begin
          start_wait(sr_wide * `CCIRS_SETTLE_PERIODS,
                     S_PH_RD);
        end
        S_PH_RD: begin
          start_op(1'b1, `CCIRS_PHASE_ADDR, 8'h00, S_PH_CHK,
                   1'b0);
        end
        S_PH_CHK: begin
          if (sh_in_reg[`CCIRS_PHASE_BIT]) begin
            phases_ok_reg   <= 1'b1;
            slave_sysref_en <= 1'b1;
            state_reg       <= S_PLL1_RD;
          end else begin
            start_wait(POLL_GAP_CYC, S_PH_RD);
          end
        end
        S_PLL1_RD: begin
          start_op(1'b1, PLL1_ST_ADDR, 8'h00, S_PLL1_CHK, 1'b0);
        end
        S_PLL1_CHK: begin
          // Slaves may already be brought up while this poll runs.
          if (sh_in_reg[PLL1_ST_BIT]) begin
            pll1_lock_reg <= 1'b1;
            state_reg     <= S_IDLE;
          end else begin
            start_wait(POLL_GAP_CYC, S_PLL1_RD);
          end
        end
        S_PULSE: begin
          start_op(1'b0, PULSE_ADDR, PULSE_VAL, S_IDLE,
                   1'b1);
        end
        S_SHUT_CH: begin
          start_op(1'b0, chan_addr_reg, chan_data_reg & ~CHAN_EN_MASK,
                   S_IDLE, 1'b0);
        end
        S_RS_CH: begin
          // Channel data carries the enable and sync enable bits.
          start_op(1'b0, chan_addr_reg, chan_data_reg, S_RS_SEED,
                   1'b0);
        end
        S_RS_SEED: begin
          // Reseed before slaves listen again, so they see an aligned edge.
          start_op(1'b0, RESEED_ADDR, RESEED_VAL, S_RS_SLV,
                   1'b1);
        end
        S_RS_SLV: begin
          slave_sysref_en <= 1'b1;
          state_reg       <= S_IDLE;
          if (rs_pulse_reg) begin
            start_wait(sr_wide * `CCIRS_PULSE_PERIODS,
                       S_PULSE);
          end
        end
        S_SPI: begin
          // Shift on falling edges, sample miso just before each fall.
          if (tick) begin
            if (!spi_sclk) begin
              spi_sclk <= 1'b1;
            end else begin
              spi_sclk   <= 1'b0;
              sh_in_reg  <= {sh_in_reg[6:0], miso_s};
              sh_out_reg <= {sh_out_reg[22:0], 1'b0};
              spi_mosi   <= sh_out_reg[22];
              bit_reg    <= bit_reg + 5'h01;
              if (bit_reg == `CCIRS_LAST_BIT) begin
                spi_cs_n  <= 1'b1;
                state_reg <= S_GAP;
              end
            end
          end
        end
        S_GAP: begin
          last_rd_reg <= sh_in_reg;
          if (tick) begin
            if (clr_after_reg) begin
              start_op(1'b0, op_addr_reg, 8'h00, ret_reg, 1'b0);
            end else begin
              state_reg <= ret_reg;
            end
          end
        end
        S_WAIT: begin
          if (wait_reg <= 32'h0000_0001) begin
            state_reg <= ret_reg;
          end else begin
            wait_reg <= wait_reg - 32'h0000_0001;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

endmodule // ccirs_ctrl

`default_nettype wire

// [verif/ccirs_ctrl_sva.sv]
// Checker of the sequencer's device pin rules.
`default_nettype none
module ccirs_ctrl_sva (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Device pins
  input wire logic dev_reset,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  // Board status and slave control
  input wire logic supply_ok,
  input wire logic slave_sysref_en
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========
  // Helper logic
  logic [4:0] rise_cnt;
  logic       sclk_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rise_cnt <= 5'h00;
      sclk_q   <= 1'b0;
    end else begin
      sclk_q   <= spi_sclk;
      rise_cnt <= spi_cs_n ? 5'h00 : rise_cnt + {4'h0, spi_sclk & ~sclk_q};
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========
  // Assertions
  AST_RST_VALUES:
    assert property ($rose(hresetn) |-> dev_reset && spi_cs_n
      && !spi_sclk && !slave_sysref_en) else $error("bad reset values");
  AST_RST_HOLD:
    assert property ($fell(dev_reset) |-> $past(dev_reset, 15))
      else $error("device reset too short");
  AST_SUPPLY_FIRST:
    assert property ($fell(dev_reset) |-> $past(supply_ok, 2))
      else $error("reset released without supplies");
  AST_QUIET_IN_RESET:
    assert property (dev_reset |-> spi_cs_n) else $error("frame in reset");
  AST_QUIET_AFTER_REL:
    assert property ($fell(dev_reset) |-> spi_cs_n [*8])
      else $error("frame too soon after release");
  AST_SCLK_IDLE:
    assert property (spi_cs_n |-> !spi_sclk) else $error("sclk not idle");
  AST_MOSI_STABLE:
    assert property ($rose(spi_sclk) |-> $stable(spi_mosi))
      else $error("mosi moved at sclk rise");
  AST_FRAME_BITS:
    assert property ($rose(spi_cs_n) |-> rise_cnt == 5'h18)
      else $error("frame not 24 bits");
endmodule // ccirs_ctrl_sva

bind ccirs_ctrl ccirs_ctrl_sva chk_u (
  .hclk            (hclk),
  .hresetn         (hresetn),
  .dev_reset       (dev_reset),
  .spi_sclk        (spi_sclk),
  .spi_cs_n        (spi_cs_n),
  .spi_mosi        (spi_mosi),
  .supply_ok       (supply_ok),
  .slave_sysref_en (slave_sysref_en)
);
`default_nettype wire

// [verif/ccirs_dev_model.sv]
// Behavioural model of the clock chip's serial port and status flags.
`default_nettype none
module ccirs_dev_model (
  // Serial link
  input  wire logic spi_sclk,
  input  wire logic spi_cs_n,
  input  wire logic spi_mosi,
  output var  logic spi_miso,
  // Slave enable, logged per write
  input  wire logic slave_en
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  mem [0:32767];
  logic [23:0] sh;
  logic [15:0] hdr;
  int          nbit;
  logic [22:0] wlog [$];
  logic        slog [$];
  time         tlog [$];
  int          restarts = 0;
  int          pulses = 0;
  time         t_start = 0, t_reseed = 0, t_phase = 0, t_pulse = 0;
  int          pll2_dly = 1500;
  int          pll1_dly = 3000;
  int          phase_dly = 900;
  initial spi_miso = 1'b0;
  initial foreach (mem[i]) mem[i] = 8'h00;
  // ==========
  // Serial framing
  always @(negedge spi_cs_n) begin
    nbit = 0;
    t_start = $time;
  end
  always @(posedge spi_sclk) begin
    if (!spi_cs_n) begin
      sh = {sh[22:0], spi_mosi};
      nbit++;
      if (nbit == 16) hdr = sh[15:0];
    end
  end
  // Outside read data bits miso toggles at each sclk fall and at spi_cs_n rise so stale data cannot pass.
  always @(negedge spi_sclk)
    spi_miso <= (!spi_cs_n && hdr[15] && nbit >= 16 && nbit < 24) ?
                mem[hdr[14:0]][23 - nbit] : ~spi_miso;
  always @(posedge spi_cs_n) begin
    spi_miso <= ~spi_miso;
    if (nbit == 24) frame_done();
  end
  // ==========
  // Register effects
  task automatic frame_done();
    logic [7:0] prev;
    prev = mem[hdr[14:0]];
    if (hdr[15]) begin
      if (hdr[14:0] == 15'h007d && t_phase < t_reseed) t_phase = t_start;
    end else begin
      mem[hdr[14:0]] = sh[7:0];
      wlog.push_back({hdr[14:0], sh[7:0]});
      slog.push_back(slave_en);
      tlog.push_back(t_start);
      if (hdr[14:0] == 15'h0001 && prev == 8'h01 && sh[7:0] == 8'h00) begin
        restarts++;
        mem[3] = 8'h00;
        mem[4] = 8'h00;
        fork
          begin
            #(pll2_dly) mem[3] = 8'h01;
            #(pll1_dly) mem[4] = 8'h01;
          end
        join_none
      end
      if (hdr[14:0] == 15'h0002 && prev == 8'h01 && sh[7:0] == 8'h00) begin
        t_reseed = t_start;
        mem[15'h007d] = 8'h00;
        fork
          #(phase_dly) if (mem[3][0]) mem[15'h007d] = 8'h04;
        join_none
      end
      if (hdr[14:0] == 15'h0002 && sh[7:0] == 8'h02) t_pulse = t_start;
      if (hdr[14:0] == 15'h0002 && prev == 8'h02 && sh[7:0] == 8'h00)
        pulses++;
    end
  endtask
endmodule // ccirs_dev_model
`default_nettype wire

// [verif/ccirs_ctrl_tb.sv]
// Self-checking bench of the init sequencer against a device model.
`default_nettype none
module ccirs_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int FRAME_NS = 1920;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        supply_ok = 1'b0;
  logic        refs_ok = 1'b0;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, dev_reset, spi_sclk, spi_cs_n;
  wire         spi_mosi, spi_miso, slave_sysref_en;
  int          error_cnt = 0;
  int          checked = 0;
  int          cycles = 0;
  logic [31:0] rnd = 32'h0000_47b6;
  logic [31:0] rd;
  logic [14:0] ca;
  logic [7:0]  cd;
  logic [22:0] exp_q [$];

  ccirs_ctrl #(.VCO_WAIT_CYC(50), .POLL_GAP_CYC(4)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .dev_reset(dev_reset), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .supply_ok(supply_ok), .ref_present(refs_ok), .vcxo_powered(refs_ok),
    .slave_sysref_en(slave_sysref_en));
  ccirs_dev_model m_u (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .slave_en(slave_sysref_en));

  always #5 hclk = ~hclk;
  // ==========
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] rw_mask(input int i);
    return (i == 0) ? 32'h7f : (i == 1) ? 32'hffff :
           (i == 2) ? 32'h7fff : 32'hff;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string msg);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s: %h not %h", $time, msg, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wait_idle();
    repeat (3) @(posedge hclk);
    do bus(1'b0, 8'h04, 32'h0); while (rd[0] !== 1'b0);
  endtask
  task automatic push_pair(input logic [14:0] a, input logic [7:0] v);
    exp_q.push_back({a, v});
    exp_q.push_back({a, 8'h00});
  endtask
  task automatic check_log();
    chk(m_u.wlog.size(), exp_q.size(), "write count");
    foreach (exp_q[i]) chk(m_u.wlog[i], exp_q[i], "write order");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // A hang anywhere ends in the same report.
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 60000) begin
      error_cnt++;
      $display("[FAIL] %0t timeout", $time);
      wrap_up();
    end
  end
  // ==========
  // Scenarios
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0000_0064, "sysref reset value");
    chk(hresp, 1'b0, "okay response");
    bus(1'b1, 8'h24, rnd);
    bus(1'b0, 8'h24, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      bus(1'b1, 8'h08 + 8'(4 * i), rnd);
      bus(1'b0, 8'h08 + 8'(4 * i), 32'h0);
      chk(rd, rnd & rw_mask(i), "register readback");
    end
    rnd = lfsr(rnd);
    ca = {7'h01, rnd[7:0]};
    cd = rnd[15:8] | 8'h01;
    bus(1'b1, 8'h10, {17'h0, ca});
    bus(1'b1, 8'h14, {24'h0, cd});
    bus(1'b1, 8'h0c, 32'h0000_000a);
    bus(1'b1, 8'h08, 32'h0000_0004);
    bus(1'b1, 8'h18, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      exp_q.push_back({7'h01, rnd[7:0], rnd[15:8]});
      bus(1'b1, 8'h1c, {9'h0, exp_q[i]});
    end
    bus(1'b1, 8'h00, 32'h1);
    repeat (100) @(posedge hclk);
    chk(dev_reset, 1'b1, "reset held without supply");
    chk(m_u.wlog.size(), 0, "no frames without supply");
    supply_ok <= 1'b1;
    while (m_u.wlog.size() < 4) @(posedge hclk);
    repeat (300) @(posedge hclk);
    chk(m_u.restarts, 0, "restart without references");
    refs_ok <= 1'b1;
    wait_idle();
    push_pair(15'h0001, 8'h01);
    push_pair(15'h0002, 8'h01);
    check_log();
    chk(rd[4:0], 5'h1e, "status after init");
    chk(m_u.tlog[4] - m_u.tlog[3] >= FRAME_NS + 500, 1'b1, "vco");
    chk(m_u.t_phase - m_u.t_reseed >= FRAME_NS + 600, 1'b1,
        "settle");
    bus(1'b1, 8'h00, 32'h2);
    wait_idle();
    push_pair(15'h0002, 8'h02);
    check_log();
    chk(m_u.pulses, 1, "pulse count");
    bus(1'b1, 8'h00, 32'h4);
    wait_idle();
    exp_q.push_back({ca, cd & 8'hfe});
    check_log();
    chk(m_u.slog[$], 1'b0, "slaves ignore first");
    m_u.phase_dly = 100;
    bus(1'b1, 8'h00, 32'h18);
    bus(1'b1, 8'h00, 32'h2);
    wait_idle();
    exp_q.push_back({ca, cd});
    push_pair(15'h0002, 8'h01);
    push_pair(15'h0002, 8'h02);
    check_log();
    chk(m_u.mem[ca], cd, "channel kept");
    chk(m_u.slog[$ - 2], 1'b0, "slaves off during reseed");
    chk(m_u.slog[$ - 1], 1'b1, "slaves on before pulse");
    chk(m_u.t_pulse - m_u.t_reseed >= FRAME_NS + 2000, 1'b1,
        "gap");
    chk(m_u.pulses, 2, "busy command dropped");
    bus(1'b1, 8'h00, 32'h1);
    repeat (40) @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk({dev_reset, spi_cs_n, slave_sysref_en}, 3'b110, "in reset");
    hresetn <= 1'b1;
    repeat (5) @(posedge hclk);
    wrap_up();
  end
endmodule // ccirs_ctrl_tb
`default_nettype wire
